/* File: core/csx_exec.sv */
// Execution of compare-skip-greater, compare-skip-less, subtract-with-borrow
// Overview of operation
// - Compare-greater skips next instruction when register exceeds working reg
// - Compare-greater opcode is 0110 010a plus 8-bit address
// - Compare-less skips next instruction when register below working reg
// - Compare-less opcode is 0110 000a plus 8-bit address
// - Compare takes one cycle, two when skipping
// - Skipping a two-word instruction takes three cycles total
// - Access bit zero selects the shared access bank
// - Access bit one combines bank select register and field
// - Access zero, extended set, field up to 95 gives indexed mode
// - Subtract-with-borrow computes register minus working minus not-carry
// - Subtract-with-borrow opcode is 0101 10da plus address
// - Subtract updates N, OV, C, DC, Z; compares touch no flag
// - Destination bit zero writes working register, one writes file
// - Instruction cycle is four phases: decode, address, read, process; write strobe in next Q1
// - Second word carries ones on top and acts as no-op
`timescale 1ns/1ns
`default_nettype none
`include "csx_consts.svh"
module csx_exec
	import csx_pkg::*;
(
	input wire logic CLK, // Core clock
	input wire logic RST_N, // Asynchronous reset, active low
	input wire logic CE, // Clock enable, freezes state when low
	input wire logic [15:0] INSTR, // Fetched instruction word
	input wire logic EXT_EN, // Extended instruction set enable
	input wire logic [3:0] BANK_SELECT_REGISTER, // Bank select value
	input wire logic [11:0] INDEX_BASE, // Base for indexed offset mode
	input wire logic [7:0] RD_DATA, // File register read data
	input wire logic [7:0] WR_W_DATA, // Working register load value
	input wire logic WR_W, // Load working register from outside
	output logic [1:0] PHASE, // Current quarter of the cycle
	output logic INSTR_TAKE, // Instruction word sampled this clock
	output logic [11:0] ADDR, // Data address of the operand
	output logic INDEXED, // Operand resolved in indexed mode
	output logic RD_EN, // File register read strobe
	output logic WR_EN, // File register write strobe
	output logic [7:0] WR_DATA, // File register write data
	output logic [7:0] WORKING_REGISTER, // Working register value
	output logic NEGATIVE_FLAG, // Negative status flag
	output logic OVERFLOW_FLAG, // Overflow status flag
	output logic CARRY_FLAG, // Carry status flag
	output logic DIGIT_CARRY_FLAG, // Digit carry status flag
	output logic ZERO_FLAG, // Zero status flag
	output logic SKIPPING, // Current cycle is a discarded no-op
	output logic UNKNOWN_OP // Word is not one of this unit's ops
);
	import csx_pkg::*;

	typedef struct packed {
		csx_phase_t phase;
		csx_op_t op;
		logic dest;
		logic access_sel;
		logic [7:0] field;
		logic [11:0] addr;
		logic indexed;
		logic [7:0] operand;
		logic [7:0] result;
		logic [7:0] w;
		csx_flags_t flags;
		logic skip_pend;
		logic skipping;
		logic wr_en;
		logic [7:0] wr_data;
		logic unknown;
	} csx_state_t;

	csx_state_t st;
	csx_state_t next_st;
	logic [11:0] res_addr;
	logic res_indexed;
	logic [8:0] diff;
	logic [4:0] low_diff;
	logic borrow_in;

	// Decode of the word held at the opening phase
	function automatic csx_op_t decode_op(input logic [15:0] word);
		if (word[15:9] == `CSX_OP_CPGT) begin
			return CSX_CPGT;
		end else if (word[15:9] == `CSX_OP_CPLT) begin
			return CSX_CPLT;
		end else if (word[15:10] == `CSX_OP_SUBB) begin
			return CSX_SUBB;
		end
		return CSX_NONE;
	endfunction : decode_op

	csx_addr u_addr (
		.field(st.field),
		.access_sel(st.access_sel),
		.ext_en(EXT_EN),
		.bank(BANK_SELECT_REGISTER),
		.index_base(INDEX_BASE),
		.addr(res_addr),
		.indexed(res_indexed)
	);

	assign borrow_in = st.op == CSX_SUBB ? ~st.flags.c : 1'b0;
	assign diff = {1'b0, st.operand} - {1'b0, st.w} - {8'h00, borrow_in};
	assign low_diff = {1'b0, st.operand[3:0]} - {1'b0, st.w[3:0]}
		- {4'h0, borrow_in};

	always_comb begin
		next_st = st;
		next_st.wr_en = 1'b0;
		unique case (st.phase)
			CSX_Q1: begin
				next_st.phase = CSX_Q2;
				if (st.skip_pend) begin
					next_st.skipping = 1'b1;
					next_st.op = CSX_NONE;
					next_st.unknown = 1'b0;
					next_st.skip_pend = 1'b0;
				end else begin
					next_st.skipping = 1'b0;
					next_st.op = decode_op(INSTR);
					next_st.unknown = decode_op(INSTR) == CSX_NONE;
					next_st.dest = INSTR[9];
					next_st.access_sel = INSTR[8];
					next_st.field = INSTR[7:0];
				end
			end
			CSX_Q2: begin
				next_st.phase = CSX_Q3;
				next_st.addr = res_addr;
				next_st.indexed = res_indexed;
			end
			CSX_Q3: begin
				next_st.phase = CSX_Q4;
				next_st.operand = RD_DATA;
			end
			CSX_Q4: begin
				next_st.phase = CSX_Q1;
				next_st.result = diff[7:0];
				unique case (st.op)
					CSX_CPGT: next_st.skipping = st.operand > st.w;
					CSX_CPLT: next_st.skipping = st.operand < st.w;
					CSX_SUBB: begin
						if (st.dest) begin
							next_st.wr_en = 1'b1;
							next_st.wr_data = diff[7:0];
						end else begin
							next_st.w = diff[7:0];
						end
						next_st.flags.n = diff[7];
						next_st.flags.z = diff[7:0] == 8'h00;
						next_st.flags.ov = (st.operand[7] != st.w[7])
							&& (diff[7] != st.operand[7]);
						next_st.flags.c = ~diff[8];
						next_st.flags.dc = ~low_diff[4];
					end
					// a pending second word keeps the skip up
					default: next_st.skipping = st.skip_pend;
				endcase
				if (WR_W) begin
					next_st.w = WR_W_DATA;
				end
			end
		endcase
	end

	// Skip decision for the following cycle needs the fetched word at Q1;
	// the discarded word's top nibble tells whether it has a second word.
	csx_state_t gated;
	always_comb begin
		gated = next_st;
		if (st.phase == CSX_Q1 && st.skipping && !st.skip_pend
			&& !next_st.skipping) begin
			gated.skipping = 1'b1;
			gated.op = CSX_NONE;
			gated.unknown = 1'b0;
			gated.skip_pend = is_two_word(INSTR);
		end
	end

	function automatic logic is_two_word(input logic [15:0] word);
		return word[15:12] == 4'hC || word[15:12] == 4'hE;
	endfunction : is_two_word

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0;
			st.w <= `CSX_W_RESET;
		end else if (CE) begin
			st <= gated;
		end
	end

	assign PHASE = st.phase;
	assign INSTR_TAKE = CE && st.phase == CSX_Q1;
	assign ADDR = st.addr;
	assign INDEXED = st.indexed;
	assign RD_EN = st.phase == CSX_Q3 && st.op != CSX_NONE;
	assign WR_EN = st.wr_en;
	assign WR_DATA = st.wr_data;
	assign WORKING_REGISTER = st.w;
	assign NEGATIVE_FLAG = st.flags.n;
	assign OVERFLOW_FLAG = st.flags.ov;
	assign CARRY_FLAG = st.flags.c;
	assign DIGIT_CARRY_FLAG = st.flags.dc;
	assign ZERO_FLAG = st.flags.z;
	assign SKIPPING = st.skipping;
	assign UNKNOWN_OP = st.unknown;
endmodule : csx_exec
`default_nettype wire

/* File: core/csx_consts.svh */
// Constant macros for the compare-skip and subtract-with-borrow unit
`ifndef CSX_CONSTS_SVH
`define CSX_CONSTS_SVH
`define CSX_OP_CPGT 7'h32
`define CSX_OP_CPLT 7'h30
`define CSX_OP_SUBB 6'h16
`define CSX_TWO_WORD_TAG 4'hF
`define CSX_IDX_LIMIT 8'h5F
`define CSX_ACC_SPLIT 8'h80
`define CSX_ACC_HI_BANK 4'hF
`define CSX_PHASES 2'h3
`define CSX_W_RESET 8'h00
`define CSX_BANK_RESET 4'h0
`endif

/* File: core/csx_pkg.sv */
// Types shared by the compare-skip and subtract-with-borrow unit
package csx_pkg;
	typedef enum logic [1:0] {
		CSX_Q1 = 2'b00,
		CSX_Q2 = 2'b01,
		CSX_Q3 = 2'b11,
		CSX_Q4 = 2'b10
	} csx_phase_t;
	typedef enum logic [1:0] {
		CSX_NONE = 2'b00,
		CSX_CPGT = 2'b01,
		CSX_CPLT = 2'b11,
		CSX_SUBB = 2'b10
	} csx_op_t;
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} csx_flags_t;
endpackage : csx_pkg

/* File: core/csx_addr.sv */
// Operand address resolution for byte-oriented instructions
`timescale 1ns/1ns
`default_nettype none
`include "csx_consts.svh"
module csx_addr (
	input wire logic [7:0] field, // Register address field
	input wire logic access_sel, // Access-select bit
	input wire logic ext_en, // Extended instruction set on
	input wire logic [3:0] bank, // Bank select register
	input wire logic [11:0] index_base, // Index pointer for offset mode
	output logic [11:0] addr, // Resolved data address
	output logic indexed // Indexed offset mode in use
);
	always_comb begin
		indexed = 1'b0;
		if (access_sel) begin
			addr = {bank, field};
		end else if (ext_en && field <= `CSX_IDX_LIMIT) begin
			indexed = 1'b1;
			addr = index_base + {4'h0, field};
		end else if (field < `CSX_ACC_SPLIT) begin
			addr = {4'h0, field};
		end else begin
			addr = {`CSX_ACC_HI_BANK, field};
		end
	end
endmodule : csx_addr
`default_nettype wire

/* File: sim/csx_checker.sv */
// Concurrent checks for the compare-skip and subtract unit
`timescale 1ns/1ns
`default_nettype none
module csx_checker (
	input wire logic CLK, // Clock
	input wire logic RST_N, // Reset
	input wire logic CE, // Enable
	input wire logic [15:0] INSTR, // Word
	input wire logic EXT_EN, // Extended set
	input wire logic [3:0] BANK_SELECT_REGISTER, // Bank
	input wire logic [1:0] PHASE, // Quarter
	input wire logic INSTR_TAKE, // Word taken
	input wire logic [11:0] ADDR, // Address
	input wire logic INDEXED, // Indexed
	input wire logic WR_EN, // Write
	input wire logic SKIPPING, // Discard
	input wire logic NEGATIVE_FLAG, // N
	input wire logic OVERFLOW_FLAG, // OV
	input wire logic CARRY_FLAG, // C
	input wire logic DIGIT_CARRY_FLAG, // DC
	input wire logic ZERO_FLAG // Z
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire logic [4:0] fl = {NEGATIVE_FLAG, OVERFLOW_FLAG, CARRY_FLAG,
		DIGIT_CARRY_FLAG, ZERO_FLAG};
	wire logic cmp = INSTR_TAKE && INSTR[15:11] == 5'h0C && !INSTR[9];
	wire logic dec = cmp || INSTR_TAKE && INSTR[15:10] == 6'h16;
	a_phase_step: assert property (
		PHASE == 2'h0 && CE |=> PHASE == 2'h1) else $error("phase stuck");
	a_write_pulse: assert property (
		WR_EN |-> PHASE == 2'h0 ##1 !WR_EN) else $error("bad write pulse");
	// Old result lands on the take edge, so checking starts two edges on
	a_cmp_flags: assert property (
		cmp |-> ##2 $stable(fl)[*4]) else $error("compare moved a flag");
	a_skip_len: assert property (
		$rose(SKIPPING) |-> SKIPPING[*4]) else $error("short skip");
	a_skip_cause: assert property (
		$rose(SKIPPING) |-> $past(INSTR_TAKE, 4) &&
		$past(INSTR[15:11], 4) == 5'h0C) else $error("skip without compare");
	a_bank_addr: assert property (
		dec && INSTR[8] |-> ##3 SKIPPING || !INDEXED && ADDR ==
		{$past(BANK_SELECT_REGISTER, 2), $past(INSTR[7:0], 3)})
		else $error("banked address wrong");
	a_access_bank: assert property (
		dec && !INSTR[8] && !EXT_EN |-> ##3 SKIPPING ||
		ADDR == {{4{$past(INSTR[7], 3)}}, $past(INSTR[7:0], 3)})
		else $error("access bank address wrong");
	a_index_mode: assert property (
		dec && !INSTR[8] && EXT_EN && INSTR[7:0] <= 8'h5F |-> ##3
		SKIPPING || INDEXED) else $error("indexed mode missed");
	c_skip: cover property ($rose(SKIPPING));
	c_write: cover property (WR_EN);
	c_indexed: cover property (INDEXED);
endmodule : csx_checker
bind csx_exec csx_checker i_chk (.*);
`default_nettype wire

/* File: sim/csx_exec_bench.sv */
// Self-checking bench for the compare-skip and subtract unit
`timescale 1ns/1ns
`default_nettype none
module csx_exec_bench;
	import csx_pkg::*;
	logic CLK = 0, RST_N = 0, EXT_EN = 0, WR_W = 0;
	logic [15:0] INSTR = 16'hF000;
	logic [3:0] BANK_SELECT_REGISTER = 4'h5;
	logic [7:0] RD_DATA = 8'h00, WR_W_DATA = 8'h00, WR_DATA, WORKING_REGISTER;
	logic [1:0] PHASE;
	logic [11:0] ADDR;
	logic [11:0] INDEX_BASE = 12'h100;
	logic INSTR_TAKE, INDEXED, RD_EN, WR_EN, SKIPPING, UNKNOWN_OP;
	csx_flags_t fl;
	int mismatches = 0, checks = 0, cyc = 0;
	always #5 CLK = ~CLK;
	csx_exec i_dut (.CE(1'b1), .NEGATIVE_FLAG(fl.n),
		.OVERFLOW_FLAG(fl.ov), .CARRY_FLAG(fl.c), .DIGIT_CARRY_FLAG(fl.dc),
		.ZERO_FLAG(fl.z), .*);
	task automatic report_and_stop;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 1000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One instruction, back to back; a load of W lands on its last edge
	task automatic op(input logic [15:0] w, input logic [7:0] rd,
		input logic [8:0] ld);
		INSTR <= w;
		RD_DATA <= rd;
		{WR_W, WR_W_DATA} <= ld;
		repeat (4) @(posedge CLK);
	endtask : op
	// Filler word keeps the phase running while results are read
	task automatic settle;
		INSTR <= 16'hF000;
		WR_W <= 1'b0;
		// The write strobe stands only until the next edge
		@(negedge CLK);
	endtask : settle
	task automatic resume;
		repeat (4) @(posedge CLK);
	endtask : resume
	task automatic borrow(input logic [7:0] wv, input logic [15:0] w,
		input logic [7:0] rd, input logic [7:0] er, input logic [4:0] ef);
		op(16'hF000, 8'h00, {1'b1, wv});
		op(w, rd, 9'h000);
		settle;
		chk(WR_EN, w[9]);
		chk(w[9] ? WR_DATA : WORKING_REGISTER, er);
		chk(WORKING_REGISTER, w[9] ? wv : er);
		chk(fl, ef);
		resume;
	endtask : borrow
	task automatic test_skip;
		logic [31:0] t [6] = '{32'h6510_1101, 32'h6510_1000, 32'h6510_9001,
			32'h6110_0F01, 32'h6110_1000, 32'h6110_9000};
		op(16'hF000, 8'h00, 9'h110);
		foreach (t[i]) begin
			op(t[i][31:16], t[i][15:8], 9'h000);
			op(16'h5B20, 8'h55, 9'h000);
			settle;
			chk(WR_EN, !t[i][0]);
			resume;
		end
		op(16'h6510, 8'h11, 9'h000);
		op(16'hC123, 8'h00, 9'h000);
		op(16'h5B20, 8'h55, 9'h000);
		settle;
		chk(WR_EN, 1'b0);
		resume;
	endtask : test_skip
	task automatic test_addr;
		logic [35:0] t [5] = '{36'h0_6134_0534, 36'h0_6034_0034,
			36'h0_6090_0F90, 36'h1_605F_115F, 36'h1_6060_0060};
		foreach (t[i]) begin
			EXT_EN <= t[i][32];
			op(t[i][31:16], 8'hFF, 9'h000);
			settle;
			chk(INDEXED, t[i][12]);
			chk(ADDR, t[i][11:0]);
			resume;
		end
	endtask : test_addr
	initial begin
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		borrow(8'h1A, 16'h5920, 8'h1B, 8'h00, 5'h07);
		borrow(8'h0D, 16'h5B20, 8'h19, 8'h0C, 5'h01);
		borrow(8'h0E, 16'h5B20, 8'h03, 8'hF5, 5'h10);
		test_skip;
		test_addr;
		report_and_stop;
	end
endmodule : csx_exec_bench
`default_nettype wire
